//--- hdl/vsp_device.sv
// Device end of the voice serial port: timing master of the link.
// Assumes a 40 MHz clk_i; the bit clock is divided from it.
//
// Notes on behaviour
// - Device drives clock, sync, downlink; host uplink.
// - Samples are 13 bits in 16-bit words.
// - Bits 15..3 hold sample, 2..0 undefined.
// - Host shifts received word right arithmetically three.
// - Words go out most significant bit first.
// - Both directions start MSB on same edge.
// - Frame sync repeats every 125 us.
// - Sync high half frame, low half frame.
// - Bit clock runs continuously near 128 kHz.
// - Bit clock phases 3.9 us, never below 3.8.
// - Downlink bit changes on bit clock rising.
// - Host holds uplink stable around falling edge.
// - Sync changes only mid low phase.
`default_nettype none

module vsp_device
  import vsp_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic [SAMPLE_BITS-1:0] dl_sample_i,
  output logic      [SAMPLE_BITS-1:0] ul_sample_o,
  output logic                        ul_valid_o,
  vsp_link_if.device                  link
);

  // ************************************************************
  // State
  // ************************************************************
  logic [HALF_W-1:0]      half_reg;
  logic [HALF_W-1:0]      half_next;
  logic                   bclk_reg;
  logic                   bclk_next;
  logic [IDX_W-1:0]       idx_reg;
  logic [IDX_W-1:0]       idx_next;
  logic                   sync_reg;
  logic                   sync_next;
  logic                   dl_reg;
  logic                   dl_next;
  logic [WORD_BITS-1:0]   dl_sh_reg;
  logic [WORD_BITS-1:0]   dl_sh_next;
  logic [WORD_BITS-1:0]   ul_sh_reg;
  logic [WORD_BITS-1:0]   ul_sh_next;
  logic [SAMPLE_BITS-1:0] ul_word_reg;
  logic [SAMPLE_BITS-1:0] ul_word_next;
  logic                   ul_valid_reg;
  logic                   ul_valid_next;
  logic                   ul_meta_reg;
  logic                   ul_sync_reg;

  logic                   phase_end;
  logic                   rise;
  logic                   fall;
  logic [IDX_W-1:0]       idx_after;
  logic [WORD_BITS-1:0]   dl_word;
  logic [WORD_BITS-1:0]   ul_word_full;

  // ************************************************************
  // Uplink pin synchroniser
  // ************************************************************
  // Two stages are harmless here: the bit holds a whole half period
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ul_meta_reg <= 1'b0;
      ul_sync_reg <= 1'b0;
    end
    else
    begin
      ul_meta_reg <= link.voice_uplink_data_line;
      ul_sync_reg <= ul_meta_reg;
    end
  end

  // ************************************************************
  // Bit timing and frame sync
  // ************************************************************
  // Half period rounds down: stays above the 3.8 us floor
  always_comb
  begin
    phase_end = (half_reg == HALF_LAST);
    rise      = phase_end && !bclk_reg;
    fall      = phase_end && bclk_reg;
    idx_after = idx_reg + 4'h1;

    half_next = phase_end ? '0 : half_reg + 8'h01;
    bclk_next = phase_end ? !bclk_reg : bclk_reg;
    idx_next  = rise ? idx_after : idx_reg;
    sync_next = sync_reg;

    // Sync moves mid low phase: setup and hold both ~1.95 us
    if (!bclk_reg && half_reg == SYNC_POINT)
    begin
      sync_next = (idx_after < SYNC_BITS);
    end
  end

  // Index parks on the last bit so the first rise opens a frame
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      half_reg <= '0;
      bclk_reg <= 1'b0;
      idx_reg  <= IDX_LAST;
      sync_reg <= 1'b0;
    end
    else
    begin
      half_reg <= half_next;
      bclk_reg <= bclk_next;
      idx_reg  <= idx_next;
      sync_reg <= sync_next;
    end
  end

  // ************************************************************
  // Downlink shifter
  // ************************************************************
  // Sample read once per frame; user keeps it steady around period 0
  always_comb
  begin
    dl_word    = {dl_sample_i, PAD_VALUE};
    dl_next    = dl_reg;
    dl_sh_next = dl_sh_reg;
    if (rise)
    begin
      if (idx_after == IDX_FIRST)
      begin
        dl_next    = dl_word[WORD_BITS-1];
        dl_sh_next = {dl_word[WORD_BITS-2:0], 1'b0};
      end
      else
      begin
        dl_next    = dl_sh_reg[WORD_BITS-1];
        dl_sh_next = {dl_sh_reg[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dl_reg    <= 1'b0;
      dl_sh_reg <= '0;
    end
    else
    begin
      dl_reg    <= dl_next;
      dl_sh_reg <= dl_sh_next;
    end
  end

  // ************************************************************
  // Uplink shifter
  // ************************************************************
  // Uplink taken at falling edge; host keeps it steady there
  // Pin lags by two clocks, far inside the half period
  always_comb
  begin
    ul_word_full  = {ul_sh_reg[WORD_BITS-2:0], ul_sync_reg};
    ul_sh_next    = ul_sh_reg;
    ul_word_next  = ul_word_reg;
    ul_valid_next = 1'b0;
    if (fall)
    begin
      ul_sh_next = ul_word_full;
      if (idx_reg == IDX_LAST)
      begin
        ul_word_next  = ul_word_full[WORD_BITS-1:PAD_BITS];
        ul_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ul_sh_reg    <= '0;
      ul_word_reg  <= '0;
      ul_valid_reg <= 1'b0;
    end
    else
    begin
      ul_sh_reg    <= ul_sh_next;
      ul_word_reg  <= ul_word_next;
      ul_valid_reg <= ul_valid_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign link.voice_bit_clock          = bclk_reg;
  assign link.voice_frame_sync         = sync_reg;
  assign link.voice_downlink_data_line = dl_reg;
  assign ul_sample_o                   = ul_word_reg;
  assign ul_valid_o                    = ul_valid_reg;

endmodule : vsp_device

`default_nettype wire

//--- hdl/vsp_host.sv
// Host end of the voice serial port: follows the device's clock.
// Assumes the bit clock runs freely, as the device guarantees.
`default_nettype none

module vsp_host
  import vsp_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic [SAMPLE_BITS-1:0] ul_sample_i,
  input  wire logic                   ul_load_i,
  output logic                        ul_busy_o,
  output logic      [SAMPLE_BITS-1:0] dl_sample_o,
  output logic                        dl_valid_o,
  vsp_link_if.host                    link
);

  // ************************************************************
  // System clock side
  // ************************************************************
  logic [SAMPLE_BITS-1:0] hold_reg, hold_next;
  logic                   req_reg, req_next;
  logic                   ack_meta_reg, ack_sync_reg;
  logic                   busy_reg, busy_next;
  logic                   rxt_meta_reg, rxt_sync_reg, rxt_prev_reg;
  logic [SAMPLE_BITS-1:0] dl_reg, dl_next;
  logic                   dlv_reg, dlv_next;
  // Link side, rising edge
  logic                   lreq_meta_reg, lreq_sync_reg;
  logic                   ack_reg, ack_next;
  logic [WORD_BITS-1:0]   tx_reg, tx_next;
  logic [WORD_BITS-1:0]   tsh_reg, tsh_next;
  logic                   ul_reg, ul_next;
  logic                   psync_reg;
  // Link side, falling edge
  logic                   nsync_reg;
  logic [WORD_BITS-1:0]   rsh_reg, rsh_next;
  logic [SAMPLE_BITS-1:0] rw_reg, rw_next;
  logic                   rxt_reg, rxt_next;
  logic [WORD_BITS-1:0]   rfull;
  logic [WORD_BITS-1:0]   rshift;
  logic [IDX_W-1:0]       rcnt_reg, rcnt_next;

  always_comb
  begin
    hold_next = hold_reg;
    req_next  = req_reg;
    // A load while busy is ignored; hold stays stable for the crossing
    if (ul_load_i && !busy_reg)
    begin
      hold_next = ul_sample_i;
      req_next  = !req_reg;
    end
    // Only the second stage of the ack synchroniser is safe to read
    busy_next = req_next ^ ack_sync_reg;
    dl_next   = dl_reg;
    dlv_next  = 1'b0;
    if (rxt_sync_reg != rxt_prev_reg)
    begin
      dl_next  = rw_reg;
      dlv_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hold_reg     <= '0;
      req_reg      <= 1'b0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
      busy_reg     <= 1'b0;
      rxt_meta_reg <= 1'b0;
      rxt_sync_reg <= 1'b0;
      rxt_prev_reg <= 1'b0;
      dl_reg       <= '0;
      dlv_reg      <= 1'b0;
    end
    else
    begin
      hold_reg     <= hold_next;
      req_reg      <= req_next;
      ack_meta_reg <= ack_reg;
      ack_sync_reg <= ack_meta_reg;
      busy_reg     <= busy_next;
      rxt_meta_reg <= rxt_reg;
      rxt_sync_reg <= rxt_meta_reg;
      rxt_prev_reg <= rxt_sync_reg;
      dl_reg       <= dl_next;
      dlv_reg      <= dlv_next;
    end
  end

  // ************************************************************
  // Uplink transmit on rising edges
  // ************************************************************
  always_comb
  begin
    ack_next = ack_reg;
    tx_next  = tx_reg;
    if (lreq_sync_reg != ack_reg)
    begin
      tx_next  = {hold_reg, PAD_VALUE};
      ack_next = lreq_sync_reg;
    end
    // Sync is already high at the first rising edge of a frame
    if (link.voice_frame_sync && !psync_reg)
    begin
      ul_next  = tx_reg[WORD_BITS-1];
      tsh_next = {tx_reg[WORD_BITS-2:0], 1'b0};
    end
    else
    begin
      ul_next  = tsh_reg[WORD_BITS-1];
      tsh_next = {tsh_reg[WORD_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge link.voice_bit_clock or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      lreq_meta_reg <= 1'b0;
      lreq_sync_reg <= 1'b0;
      ack_reg       <= 1'b0;
      tx_reg        <= '0;
      tsh_reg       <= '0;
      ul_reg        <= 1'b0;
      psync_reg     <= 1'b0;
    end
    else
    begin
      lreq_meta_reg <= req_reg;
      lreq_sync_reg <= lreq_meta_reg;
      ack_reg       <= ack_next;
      tx_reg        <= tx_next;
      tsh_reg       <= tsh_next;
      ul_reg        <= ul_next;
      psync_reg     <= link.voice_frame_sync;
    end
  end

  assign link.voice_uplink_data_line = ul_reg;

  // ************************************************************
  // Downlink receive on falling edges
  // ************************************************************
  always_comb
  begin
    rshift  = {rsh_reg[WORD_BITS-2:0], link.voice_downlink_data_line};
    rfull   = rshift;
    rw_next  = rw_reg;
    rxt_next = rxt_reg;
    rsh_next = rshift;
    rcnt_next = rcnt_reg + 4'h1;
    if (link.voice_frame_sync && !nsync_reg)
    begin
      rcnt_next = IDX_FIRST + 4'h1;
    end
    else if (rcnt_reg == IDX_LAST)
    begin
      // Arithmetic shift drops the undefined low bits
      rfull    = $signed(rshift) >>> PAD_BITS;
      rw_next  = rfull[SAMPLE_BITS-1:0];
      rxt_next = !rxt_reg;
    end
  end

  always_ff @(negedge link.voice_bit_clock or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      nsync_reg <= 1'b0;
      rsh_reg   <= '0;
      rw_reg    <= '0;
      rxt_reg   <= 1'b0;
      rcnt_reg  <= IDX_FIRST;
    end
    else
    begin
      nsync_reg <= link.voice_frame_sync;
      rsh_reg   <= rsh_next;
      rw_reg    <= rw_next;
      rxt_reg   <= rxt_next;
      rcnt_reg  <= rcnt_next;
    end
  end

  assign ul_busy_o   = busy_reg;
  assign dl_sample_o = dl_reg;
  assign dl_valid_o  = dlv_reg;

endmodule : vsp_host

`default_nettype wire

//--- hdl/vsp_link_if.sv
// Interface joining the voice port device end and the host end.
// Assumes all four lines are plain one-way wires.
`default_nettype none

interface vsp_link_if;
  logic voice_bit_clock;
  logic voice_frame_sync;
  logic voice_downlink_data_line;
  logic voice_uplink_data_line;

  modport device (
    output voice_bit_clock,
    output voice_frame_sync,
    output voice_downlink_data_line,
    input  voice_uplink_data_line
  );

  modport host (
    input  voice_bit_clock,
    input  voice_frame_sync,
    input  voice_downlink_data_line,
    output voice_uplink_data_line
  );
endinterface : vsp_link_if

`default_nettype wire

//--- hdl/vsp_pkg.sv
// Package of shared constants for the voice serial port ends.
// Assumes a 40 MHz system clock on both ends.
`default_nettype none

package vsp_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  // Bit clock half period, typical figure
  localparam int unsigned BIT_HALF_NS   = 3900;
  // Least half period allowed
  localparam int unsigned BIT_HALF_MIN_NS = 3800;
  // Rounds down, stays above the least figure
  localparam int unsigned BIT_HALF_CYC  = BIT_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned HALF_W        = 8;
  localparam logic [HALF_W-1:0] HALF_LAST  = HALF_W'(BIT_HALF_CYC - 1);
  // Middle of the low phase, far from both edges
  localparam logic [HALF_W-1:0] SYNC_POINT = HALF_W'(BIT_HALF_CYC / 2);

  // ************************************************************
  // Word layout
  // ************************************************************
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned SAMPLE_BITS = 13;
  localparam int unsigned PAD_BITS    = 3;
  localparam logic [PAD_BITS-1:0] PAD_VALUE = 3'h0;
  localparam int unsigned IDX_W       = 4;
  localparam logic [IDX_W-1:0] IDX_FIRST = 4'h0;
  localparam logic [IDX_W-1:0] IDX_LAST  = 4'hf;
  // Sync high for the first half of the frame
  localparam logic [IDX_W-1:0] SYNC_BITS = 4'h8;

endpackage : vsp_pkg

`default_nettype wire

//--- testbench/pcm_voice_serial_port_tb.sv
// Bench joining the device end and the host end back to back.
// Assumes both ends share one 40 MHz clock and one reset.
`default_nettype none

module pcm_voice_serial_port_tb
  import vsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic                   clk_i;
  logic                   nrst_i;
  logic [SAMPLE_BITS-1:0] dl_sample_i;
  logic [SAMPLE_BITS-1:0] ul_sample_i;
  logic [SAMPLE_BITS-1:0] ul_sample_o;
  logic [SAMPLE_BITS-1:0] dl_sample_o;
  logic                   ul_load_i;
  logic                   ul_valid_o;
  logic                   ul_busy_o;
  logic                   dl_valid_o;
  logic [15:0]            dw;
  logic [15:0]            uw;
  int                     n_errors = 0;
  int                     n_checks = 0;
  logic [25:0]            tbl [4] = '{{13'h1000, 13'h0fff}, {13'h0fff, 13'h1000},
                                      {13'h0001, 13'h1fff}, {13'h1fff, 13'h0001}};

  vsp_link_if vsp_link_if_i ();
  wire bck = vsp_link_if_i.voice_bit_clock;
  wire syn = vsp_link_if_i.voice_frame_sync;
  wire dl  = vsp_link_if_i.voice_downlink_data_line;
  wire ul  = vsp_link_if_i.voice_uplink_data_line;

  vsp_device vsp_device_i (.clk_i(clk_i), .nrst_i(nrst_i), .dl_sample_i(dl_sample_i),
    .ul_sample_o(ul_sample_o), .ul_valid_o(ul_valid_o), .link(vsp_link_if_i.device));
  vsp_host vsp_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .ul_sample_i(ul_sample_i), .ul_load_i(ul_load_i),
    .ul_busy_o(ul_busy_o), .dl_sample_o(dl_sample_o), .dl_valid_o(dl_valid_o), .link(vsp_link_if_i.host));
  vsp_link_sva vsp_link_sva_i (.clk_i(clk_i), .nrst_i(nrst_i), .voice_bit_clock(bck),
    .voice_frame_sync(syn), .voice_downlink_data_line(dl), .voice_uplink_data_line(ul));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic tick;
    @(posedge clk_i);
    #2;
  endtask : tick

  // Second load while busy must be ignored
  task automatic run_frame(input logic [12:0] d, input logic [12:0] u, input logic ld, input logic bad);
    logic gd;
    logic gu;
    gd = 1'b0;
    gu = 1'b0;
    tick;
    dl_sample_i = d;
    if (ld)
    begin
      ul_sample_i = u;
      ul_load_i = 1'b1;
      tick;
      ul_load_i = 1'b0;
      check(16'(ul_busy_o), 16'h0001);
      if (bad)
      begin
        ul_sample_i = ~u;
        ul_load_i = 1'b1;
        tick;
        ul_load_i = 1'b0;
        ul_sample_i = u;
      end
      for (int n = 0; n < 2000 && ul_busy_o !== 1'b0; n++)
        tick;
      check(16'(ul_busy_o), 16'h0000);
    end
    @(posedge syn);
    repeat (16)
    begin
      @(negedge bck);
      dw = {dw[14:0], dl};
      uw = {uw[14:0], ul};
    end
    check(dw, {d, 3'h0});
    check(uw, {u, 3'h0});
    // Uplink valid stands only the cycle after the last fall
    #2;
    for (int n = 0; n < 40; n++)
    begin
      if (dl_valid_o === 1'b1)
      begin
        gd = 1'b1;
        check(16'(dl_sample_o), 16'(d));
      end
      if (ul_valid_o === 1'b1)
      begin
        gu = 1'b1;
        check(16'(ul_sample_o), 16'(u));
      end
      tick;
    end
    check(16'({gd, gu}), 16'h0003);
  endtask : run_frame

  task automatic t_timing;
    time t0;
    time t1;
    @(posedge bck);
    t0 = $time;
    @(posedge bck);
    check(16'($time - t0), 16'(2 * BIT_HALF_CYC * CLK_PERIOD_NS));
    @(posedge syn);
    t0 = $time;
    t1 = t0;
    @(negedge syn);
    check(16'($time - t0), 16'(16 * BIT_HALF_CYC * CLK_PERIOD_NS));
    t0 = $time;
    @(posedge syn);
    check(16'($time - t0), 16'(16 * BIT_HALF_CYC * CLK_PERIOD_NS));
    // Whole frame scaled by four to fit the check width
    check(16'(($time - t1) / 4), 16'(8 * BIT_HALF_CYC * CLK_PERIOD_NS));
  endtask : t_timing

  task automatic t_reset;
    tick;
    nrst_i = 1'b0;
    repeat (4)
      tick;
    check(16'({bck, syn, dl, ul, ul_busy_o, dl_valid_o, ul_valid_o}), 16'h0000);
    check(16'(dl_sample_o | ul_sample_o), 16'h0000);
    nrst_i = 1'b1;
  endtask : t_reset

  // ************************************************************
  // Clock, sequence and watchdog
  // ************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial
  begin
    nrst_i = 1'b0;
    ul_load_i = 1'b0;
    ul_sample_i = 13'h0000;
    dl_sample_i = 13'h0000;
    repeat (20)
      tick;
    nrst_i = 1'b1;
    t_timing;
    foreach (tbl[i])
      run_frame(tbl[i][25:13], tbl[i][12:0], 1'b1, 1'b0);
    run_frame(13'h0aaa, 13'h0555, 1'b1, 1'b1);
    // Word repeats every frame until replaced
    run_frame(13'h1555, 13'h0555, 1'b0, 1'b0);
    t_reset;
    run_frame(13'h0123, 13'h0000, 1'b0, 1'b0);
    end_sim;
  end

  // Longest expected run is near 70k cycles
  initial
  begin
    #2500000;
    n_errors++;
    end_sim;
  end
endmodule : pcm_voice_serial_port_tb

`default_nettype wire

//--- testbench/vsp_link_sva.sv
// Checker for the four wires between the voice port ends.
// Assumes the bit clock is divided down from clk_i.
`default_nettype none

module vsp_link_sva (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic voice_bit_clock,
  input wire logic voice_frame_sync,
  input wire logic voice_downlink_data_line,
  input wire logic voice_uplink_data_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Helpers
  // ************************************************************
  logic [7:0] cnt_reg;
  logic [4:0] rise_reg;
  logic [4:0] pos_reg;
  logic       bck_reg;
  logic       syn_reg;
  logic       dl_reg;
  logic       ul_reg;
  logic       run_reg;
  logic       fr_reg;
  wire        rise   = voice_bit_clock & ~bck_reg;
  wire        edge_c = voice_bit_clock ^ bck_reg;
  wire        edge_s = voice_frame_sync ^ syn_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg  <= 8'h00;
      rise_reg <= 5'h00;
      pos_reg  <= 5'h00;
      bck_reg  <= 1'b0;
      syn_reg  <= 1'b0;
      dl_reg   <= 1'b0;
      ul_reg   <= 1'b0;
      run_reg  <= 1'b0;
      fr_reg   <= 1'b0;
    end
    else
    begin
      bck_reg  <= voice_bit_clock;
      syn_reg  <= voice_frame_sync;
      dl_reg   <= voice_downlink_data_line;
      ul_reg   <= voice_uplink_data_line;
      cnt_reg  <= edge_c ? 8'h00 : cnt_reg + 8'h01;
      run_reg  <= run_reg | edge_c;
      fr_reg   <= fr_reg | (edge_s & voice_frame_sync);
      rise_reg <= edge_s ? 5'h00 : rise_reg + 5'(rise);
      pos_reg  <= (edge_s & voice_frame_sync) ? 5'h00 : pos_reg + 5'(rise);
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_half_period_len: assert property (run_reg && edge_c |-> cnt_reg == 8'h9b)
    else $error("bit clock phase not 156 cycles");
  a_clock_never_stops: assert property (run_reg |-> cnt_reg <= 8'h9b)
    else $error("bit clock stalled");
  a_sync_mid_low: assert property (edge_s |-> !voice_bit_clock && cnt_reg >= 8'h4a && cnt_reg <= 8'h52)
    else $error("frame sync moved near a clock edge");
  a_sync_phase_len: assert property (fr_reg && edge_s |-> rise_reg == 5'h08)
    else $error("frame sync phase not eight bit periods");
  a_frame_bit_count: assert property (fr_reg && edge_s && voice_frame_sync |-> pos_reg == 5'h10)
    else $error("frame not sixteen bit periods");
  a_downlink_on_rise: assert property (voice_downlink_data_line != dl_reg |-> rise)
    else $error("downlink changed off a rising edge");
  a_uplink_on_rise: assert property (voice_uplink_data_line != ul_reg |-> rise)
    else $error("uplink changed off a rising edge");
  a_pad_bits_zero: assert property (!voice_bit_clock && bck_reg && pos_reg >= 5'h0e
    |-> !voice_downlink_data_line && !voice_uplink_data_line)
    else $error("pad bits not zero");
endmodule : vsp_link_sva

`default_nettype wire
